// File: hw/pwl_wake_led.v
// Purpose: wake-event enable/status registers and power lamp control
// Assumes: wake source inputs are synchronous, high while an event occurs
// Notes:   wake enables and status survive the main reset; only the
//          standby reset initialises them
`timescale 1ns/10ps
`default_nettype none
`include "pwl_regs.vh"

// Overview of operation
// - The wake request is driven active when a source has enable, status and global enable set.
// - A disabled source still records its event in status but never drives the wake request.
// - Enable register at index 0x0d holds one bit per group-one pin, bit 0 pin 10 to bit 7 pin 17.
// - Enable register at index 0x0e maps bit 1 ring two, 2 ring one, 3 keyboard, 4 mouse, 5 key, 6-7 fans.
// - Both enable registers are reset only by the standby reset, not by the main reset.
// - The register at index 0x0f is reserved and reads all zero.
// - With the sleep input high, lamp bit 0 chooses yellow at 0 and green at 1.
// - With the sleep input high, lamp bit 1 gives steady at 1 and a 0.59375 s on, 0.90625 s off blink at 0.
// - A wake status bit is cleared by writing 1 to it, and writing 0 leaves it unchanged.
module pwl_wake_led #(
  parameter integer BLINK_HIGH_CYC = `PWL_BLINK_HIGH_CYC,
  parameter integer BLINK_LOW_CYC  = `PWL_BLINK_LOW_CYC
) (
  input  wire        ref_clk_in,              // 20 MHz clock
  input  wire        rst_b_in,                // main reset, active low, async
  input  wire        stby_rst_b_in,           // standby domain reset, active low
  input  wire        wb_cyc_in,               // wishbone cycle
  input  wire        wb_stb_in,               // wishbone strobe
  input  wire        wb_we_in,                // wishbone write enable
  input  wire [7:0]  wb_adr_in,               // wishbone byte address
  input  wire [3:0]  wb_sel_in,               // wishbone byte selects
  input  wire [31:0] wb_dat_in,               // wishbone write data
  output reg  [31:0] wb_dat_out,              // wishbone read data
  output reg         wb_ack_out,              // wishbone acknowledge
  input  wire [7:0]  gpio_group1_wake_in,     // group-one pin events, bit 0 = pin 10
  input  wire        ring_indicator_two_in,   // ring indicator two event
  input  wire        ring_indicator_one_in,   // ring indicator one event
  input  wire        keyboard_wake_in,        // keyboard event
  input  wire        mouse_wake_in,           // mouse event
  input  wire        specific_key_wake_in,    // specific key event
  input  wire        fan_speed_input_one_in,  // fan tach one event
  input  wire        fan_speed_input_two_in,  // fan tach two event
  input  wire        sleep_state5_input_n_in, // sleep state 5 input
  output reg         wake_request_out_n_out,  // wake request, active low
  output reg         yellow_lamp_out,         // yellow lamp drive
  output reg         green_lamp_out,          // green lamp drive
  output reg         irq_out                  // level interrupt
);

  // ==========================================================================
  // reset synchronisers
  // main reset clears only the bus answer and the interrupt logic;
  // standby reset initialises enables, status, lamp and wake output
  reg [1:0] rst_sync_q;
  reg [1:0] stby_sync_q;
  wire      rst_n;
  wire      stby_rst_n;

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  always @(posedge ref_clk_in or negedge stby_rst_b_in) begin
    if (!stby_rst_b_in) begin
      stby_sync_q <= 2'b00;
    end else begin
      stby_sync_q <= {stby_sync_q[0], 1'b1};
    end
  end

  assign rst_n      = rst_sync_q[1];
  assign stby_rst_n = stby_sync_q[1];

  // ==========================================================================
  // bus decode
  wire [5:0] idx;
  wire       req;
  wire       wr;
  wire       wr_lane0;

  assign idx      = wb_adr_in[7:2];
  // a request is taken while ack is low; a write commits at the edge where
  // the master samples ack, so it lands exactly once per transfer
  assign req      = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr       = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;
  // only byte lane 0 carries register data
  assign wr_lane0 = wr & wb_sel_in[0];

  wire wr_en_gpio;
  wire wr_en_misc;
  wire wr_sts_gpio;
  wire wr_sts_misc;
  wire wr_led;
  wire wr_ctrl;
  wire wr_irq_en;
  wire wr_irq_clr;

  assign wr_en_gpio  = wr_lane0 & (idx == `PWL_IDX_WAKE_EN_GPIO);
  assign wr_en_misc  = wr_lane0 & (idx == `PWL_IDX_WAKE_EN_MISC);
  assign wr_sts_gpio = wr_lane0 & (idx == `PWL_IDX_WAKE_STS_GPIO);
  assign wr_sts_misc = wr_lane0 & (idx == `PWL_IDX_WAKE_STS_MISC);
  assign wr_led      = wr_lane0 & (idx == `PWL_IDX_LED_CTRL);
  assign wr_ctrl     = wr_lane0 & (idx == `PWL_IDX_WAKE_CTRL);
  assign wr_irq_en   = wr_lane0 & (idx == `PWL_IDX_IRQ_EN);
  assign wr_irq_clr  = wr_lane0 & (idx == `PWL_IDX_IRQ_CLR);

  // ==========================================================================
  // wake sources
  wire [7:0] misc_evt;

  assign misc_evt = {fan_speed_input_two_in,
                     fan_speed_input_one_in,
                     specific_key_wake_in,
                     mouse_wake_in,
                     keyboard_wake_in,
                     ring_indicator_one_in,
                     ring_indicator_two_in,
                     1'b0};

  // ==========================================================================
  // standby-domain registers: enables, status, global enable, lamp
  reg [7:0] en_gpio_q;
  reg [7:0] en_misc_q;
  reg [7:0] sts_gpio_q;
  reg [7:0] sts_misc_q;
  reg [7:0] led_q;
  reg [7:0] ctrl_q;
  wire [7:0] sts_gpio_d;
  wire [7:0] sts_misc_d;

  // events set status regardless of the enables; set wins over a clear
  assign sts_gpio_d = (sts_gpio_q & ~({8{wr_sts_gpio}} & wb_dat_in[7:0]))
                      | gpio_group1_wake_in;
  assign sts_misc_d = ((sts_misc_q & ~({8{wr_sts_misc}} & wb_dat_in[7:0]))
                      | misc_evt) & `PWL_MISC_VALID_MASK;

  always @(posedge ref_clk_in or negedge stby_rst_n) begin
    if (!stby_rst_n) begin
      en_gpio_q  <= `PWL_RST_WAKE_EN;
      en_misc_q  <= `PWL_RST_WAKE_EN;
      sts_gpio_q <= `PWL_RST_WAKE_STS;
      sts_misc_q <= `PWL_RST_WAKE_STS;
      led_q      <= `PWL_RST_LED;
      ctrl_q     <= `PWL_RST_CTRL;
    end else begin
      if (wr_en_gpio) begin
        en_gpio_q <= wb_dat_in[7:0];
      end
      if (wr_en_misc) begin
        en_misc_q <= wb_dat_in[7:0] & `PWL_MISC_VALID_MASK;
      end
      if (wr_led) begin
        led_q <= wb_dat_in[7:0] & `PWL_LED_MASK;
      end
      if (wr_ctrl) begin
        ctrl_q <= {7'h00, wb_dat_in[`PWL_CTRL_GLOBAL_EN_BIT]};
      end
      sts_gpio_q <= sts_gpio_d;
      sts_misc_q <= sts_misc_d;
    end
  end

  // ==========================================================================
  // wake request
  wire wake_any;
  // request low while any enabled status bit is set and the global enable is on

  assign wake_any = ctrl_q[`PWL_CTRL_GLOBAL_EN_BIT]
                    & (|(en_gpio_q & sts_gpio_q) | |(en_misc_q & sts_misc_q));

  always @(posedge ref_clk_in or negedge stby_rst_n) begin
    if (!stby_rst_n) begin
      wake_request_out_n_out <= 1'b1;
    end else begin
      wake_request_out_n_out <= ~wake_any;
    end
  end

  // ==========================================================================
  // power lamp
  wire blink;
  wire lamp_on;

  pwl_blink_timer #(
    .CNT_W    (`PWL_BLINK_CNT_W),
    .HIGH_CYC (BLINK_HIGH_CYC),
    .LOW_CYC  (BLINK_LOW_CYC)
  ) u_blink (
    .clk_in    (ref_clk_in),
    .rst_n_in  (stby_rst_n),
    .blink_out (blink)
  );

  // sleep input low darkens both lamps
  assign lamp_on = sleep_state5_input_n_in
                   & (led_q[`PWL_LED_STEADY_BIT] | blink);

  always @(posedge ref_clk_in or negedge stby_rst_n) begin
    if (!stby_rst_n) begin
      yellow_lamp_out <= 1'b0;
      green_lamp_out  <= 1'b0;
    end else begin
      yellow_lamp_out <= lamp_on & ~led_q[`PWL_LED_COLOUR_BIT];
      green_lamp_out  <= lamp_on & led_q[`PWL_LED_COLOUR_BIT];
    end
  end

  // ==========================================================================
  // interrupt status, enable and clear
  reg  [7:0] irq_sts_q;
  reg  [7:0] irq_en_q;
  reg        wake_q;
  reg        irq_arm_q;
  wire [7:0] irq_evt;
  wire [7:0] irq_clr;

  // a wake request that already stands when main reset ends is not a new
  // edge, so the edge detector is armed one cycle after release
  assign irq_evt = {5'h00,
                    wake_any & ~wake_q & irq_arm_q,
                    |(sts_misc_d & ~sts_misc_q),
                    |(sts_gpio_d & ~sts_gpio_q)};
  assign irq_clr = {8{wr_irq_clr}} & wb_dat_in[7:0];

  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_q <= `PWL_RST_IRQ;
      irq_en_q  <= `PWL_RST_IRQ;
      wake_q    <= 1'b0;
      irq_arm_q <= 1'b0;
      irq_out   <= 1'b0;
    end else begin
      wake_q    <= wake_any;
      irq_arm_q <= 1'b1;
      irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_evt;
      if (wr_irq_en) begin
        irq_en_q <= wb_dat_in[7:0] & `PWL_IRQ_MASK;
      end
      irq_out <= |(irq_sts_q & irq_en_q);
    end
  end

  // ==========================================================================
  // read mux
  reg [7:0] rd_byte;
  // the clear register and unmapped indices read zero

  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `PWL_IDX_WAKE_STS_GPIO: begin
        rd_byte = sts_gpio_q;
      end
      `PWL_IDX_WAKE_STS_MISC: begin
        rd_byte = sts_misc_q;
      end
      `PWL_IDX_WAKE_EN_GPIO: begin
        rd_byte = en_gpio_q;
      end
      `PWL_IDX_WAKE_EN_MISC: begin
        rd_byte = en_misc_q;
      end
      `PWL_IDX_RSVD_ZERO: begin
        rd_byte = 8'h00;
      end
      `PWL_IDX_LED_CTRL: begin
        rd_byte = led_q;
      end
      `PWL_IDX_WAKE_CTRL: begin
        rd_byte = ctrl_q;
      end
      `PWL_IDX_IRQ_STS: begin
        rd_byte = irq_sts_q;
      end
      `PWL_IDX_IRQ_EN: begin
        rd_byte = irq_en_q;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // ==========================================================================
  // wishbone answer: ack one cycle after the request, for every address
  // read data is captured at the take edge and held until the next read
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      if (req && !wb_we_in) begin
        wb_dat_out <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule
`default_nettype wire

// File: hw/pwl_regs.vh
// Purpose: constants for the wake-enable and power-lamp register bank
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes:   byte address of a register is four times its index
`ifndef PWL_REGS_VH
`define PWL_REGS_VH

// ==========================================================================
// register indices (byte address = index * 4)
`define PWL_IDX_WAKE_STS_GPIO   6'h09
`define PWL_IDX_WAKE_STS_MISC   6'h0a
`define PWL_IDX_WAKE_EN_GPIO    6'h0d
`define PWL_IDX_WAKE_EN_MISC    6'h0e
`define PWL_IDX_RSVD_ZERO       6'h0f
`define PWL_IDX_LED_CTRL        6'h10
`define PWL_IDX_WAKE_CTRL       6'h16
`define PWL_IDX_IRQ_STS         6'h20
`define PWL_IDX_IRQ_EN          6'h21
`define PWL_IDX_IRQ_CLR         6'h22

// ==========================================================================
// field positions
`define PWL_MISC_RING_TWO       1
`define PWL_MISC_RING_ONE       2
`define PWL_MISC_KEYBOARD       3
`define PWL_MISC_MOUSE          4
`define PWL_MISC_KEY_WAKE       5
`define PWL_MISC_FAN1           6
`define PWL_MISC_FAN2           7
`define PWL_MISC_VALID_MASK     8'hfe
`define PWL_LED_COLOUR_BIT      0
`define PWL_LED_STEADY_BIT      1
`define PWL_LED_MASK            8'h03
`define PWL_CTRL_GLOBAL_EN_BIT  0
`define PWL_IRQ_GPIO_BIT        0
`define PWL_IRQ_MISC_BIT        1
`define PWL_IRQ_WAKE_BIT        2
`define PWL_IRQ_MASK            8'h07

// ==========================================================================
// reset values
`define PWL_RST_WAKE_EN         8'h00
`define PWL_RST_WAKE_STS        8'h00
`define PWL_RST_LED             8'h00
`define PWL_RST_CTRL            8'h00
`define PWL_RST_IRQ             8'h00

// ==========================================================================
// timing
`define PWL_CLK_PERIOD_NS       50
`define PWL_BLINK_HIGH_NS       593750000
`define PWL_BLINK_LOW_NS        906250000
`define PWL_BLINK_HIGH_CYC      (`PWL_BLINK_HIGH_NS / `PWL_CLK_PERIOD_NS)
`define PWL_BLINK_LOW_CYC       (`PWL_BLINK_LOW_NS / `PWL_CLK_PERIOD_NS)
`define PWL_BLINK_CNT_W         25

`endif

// File: hw/pwl_blink_timer.v
// Purpose: free-running blink pattern generator for the power lamp
// Assumes: HIGH_CYC + LOW_CYC fits in CNT_W bits
// Notes:   output is high for HIGH_CYC cycles then low for LOW_CYC cycles
`timescale 1ns/10ps
`default_nettype none
module pwl_blink_timer #(
  parameter integer CNT_W    = 25,
  parameter integer HIGH_CYC = 11875000,
  parameter integer LOW_CYC  = 18125000
) (
  input  wire clk_in,                // system clock
  input  wire rst_n_in,              // synchronised reset, active low
  output reg  blink_out              // blink phase, high during on phase
);

  localparam [31:0]      LAST_32  = HIGH_CYC + LOW_CYC - 1;
  localparam [31:0]      HIGH_32  = HIGH_CYC;
  localparam [CNT_W-1:0] LAST_CNT = LAST_32[CNT_W-1:0];
  localparam [CNT_W-1:0] HIGH_END = HIGH_32[CNT_W-1:0];

  reg [CNT_W-1:0] cnt_q;

  // ==========================================================================
  // period counter
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q     <= {CNT_W{1'b0}};
      blink_out <= 1'b0;
    end else begin
      if (cnt_q == LAST_CNT) begin
        cnt_q <= {CNT_W{1'b0}};
      end else begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      blink_out <= (cnt_q < HIGH_END);
    end
  end

endmodule
`default_nettype wire

// File: verification/pwl_host_wake.sv
// Purpose: host-side receiver of the wake request line
// Assumes: wake line is active low and level
// Notes:   counts each new assertion of the request
`timescale 1ns/10ps
`default_nettype none
module pwl_host_wake (
  input  wire logic       clk_in,      // clock
  input  wire logic       rst_n_in,    // standby reset, active low
  input  wire logic       wake_n_in,   // wake request line
  output var  logic [7:0] wake_cnt_out // requests seen
);
  logic wake_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_q       <= 1'b1;
      wake_cnt_out <= 8'h00;
    end else begin
      wake_q <= wake_n_in;
      if (wake_q && !wake_n_in)
        wake_cnt_out <= wake_cnt_out + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: verification/pwl_wake_led_props.sv
// Purpose: port properties of the wake enable and lamp bank
// Assumes: one clock; bus checks gated by the main reset
// Notes:   bound to every instance of the bank
`timescale 1ns/10ps
`default_nettype none
module pwl_wake_led_props (
  input wire logic        ref_clk_in,              // clock
  input wire logic        rst_b_in,                // main reset
  input wire logic        stby_rst_b_in,           // standby reset
  input wire logic        wb_cyc_in,               // cycle
  input wire logic        wb_stb_in,               // strobe
  input wire logic        wb_we_in,                // write
  input wire logic [7:0]  wb_adr_in,               // address
  input wire logic [31:0] wb_dat_out,              // read data
  input wire logic        wb_ack_out,              // acknowledge
  input wire logic        sleep_state5_input_n_in, // lamp enable
  input wire logic        wake_request_out_n_out,  // wake request
  input wire logic        yellow_lamp_out,         // yellow lamp
  input wire logic        green_lamp_out           // green lamp
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ========
  // sequences
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_dark;
    !yellow_lamp_out && !green_lamp_out;
  endsequence
  sequence s_rsvd_rd;
    wb_ack_out && !wb_we_in && wb_adr_in[7:2] == 6'h0f;
  endsequence
  // ========
  // properties
  a_ack_follows: assert property (s_req |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  a_rsvd_zero: assert property (s_rsvd_rd |-> wb_dat_out == 32'h0)
    else $error("reserved register not zero");
  a_dat_hold: assert property (!wb_ack_out |-> $stable(wb_dat_out))
    else $error("read data moved without ack");
  a_sleep_dark: assert property (!sleep_state5_input_n_in |=> s_dark)
    else $error("lamp lit while asleep");
  a_one_lamp: assert property (!(yellow_lamp_out && green_lamp_out))
    else $error("both lamps lit");
  a_wake_stby: assert property (!stby_rst_b_in |-> wake_request_out_n_out)
    else $error("wake request during standby reset");
endmodule
bind pwl_wake_led pwl_wake_led_props u_props (.ref_clk_in, .rst_b_in, .stby_rst_b_in,
  .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out,
  .sleep_state5_input_n_in, .wake_request_out_n_out, .yellow_lamp_out, .green_lamp_out);
`default_nettype wire

// File: verification/tb.sv
// Purpose: self-checking bench of the wake enable and lamp bank
// Assumes: blink counts shortened to 5 and 8
// Notes:   reads are compared by a monitor from a queue of expected bytes
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb;
  logic        clk, rst_b, stby_b, cyc, stb, we, slp, ack, wn, yl, gl, irq;
  logic [3:0]  sel;
  logic [7:0]  adr, q, ra, sa, ea, b, wcnt;
  logic [31:0] wd, rd;
  logic [15:0] src;
  logic [7:0]  v[4];
  logic [7:0]  msk[4] = '{8'hff, 8'hfe, 8'h00, 8'h03};
  logic [7:0]  exp_q[$];
  int          n_mismatch, checks, i, k;
  pwl_wake_led #(.BLINK_HIGH_CYC(5), .BLINK_LOW_CYC(8)) u_pwl_wake_led (
    .ref_clk_in(clk), .rst_b_in(rst_b), .stby_rst_b_in(stby_b), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd),
    .wb_dat_out(rd), .wb_ack_out(ack), .gpio_group1_wake_in(src[7:0]),
    .ring_indicator_two_in(src[9]), .ring_indicator_one_in(src[10]),
    .keyboard_wake_in(src[11]), .mouse_wake_in(src[12]), .specific_key_wake_in(src[13]),
    .fan_speed_input_one_in(src[14]), .fan_speed_input_two_in(src[15]),
    .sleep_state5_input_n_in(slp), .wake_request_out_n_out(wn), .yellow_lamp_out(yl),
    .green_lamp_out(gl), .irq_out(irq));
  pwl_host_wake u_pwl_host_wake (.clk_in(clk), .rst_n_in(stby_b), .wake_n_in(wn),
    .wake_cnt_out(wcnt));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ========
  // bus master and helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hf;
    wd  <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic pulse(input int n);
    @(posedge clk);
    src[n] <= 1'b1;
    @(posedge clk);
    src[n] <= 1'b0;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ========
  // read monitor
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      q = exp_q.pop_front();
      `CHK("read", {24'h0, q}, rd)
    end
  end
  initial begin
    #(50 * 20000);
    n_mismatch++;
    stop_test();
  end
  // ========
  // tests
  initial begin
    {cyc, stb, we, adr, wd, sel, src, slp} = '0;
    rst_b = 1'b0;
    stby_b = 1'b0;
    n_mismatch = 0;
    checks = 0;
    void'($urandom(61585));
    tick(8);
    rst_b <= 1'b1;
    stby_b <= 1'b1;
    tick(3);
    for (i = 0; i < 4; i++) begin
      ra = 8'h34 + 8'(4 * i);
      rdx(ra, 8'h00);
      k = $urandom;
      v[i] = 8'(k) & msk[i];
      bus(1'b1, ra, 8'(k));
      rdx(ra, v[i]);
    end
    rdx(8'hfc, 8'h00);
    rst_b <= 1'b0;
    tick(2);
    rst_b <= 1'b1;
    tick(3);
    for (i = 0; i < 4; i++) rdx(8'h34 + 8'(4 * i), v[i]);
    stby_b <= 1'b0;
    tick(2);
    stby_b <= 1'b1;
    tick(3);
    for (i = 0; i < 4; i++) rdx(8'h34 + 8'(4 * i), 8'h00);
    $display("test registers done");
    bus(1'b1, 8'h58, 8'h01);
    for (i = 0; i < 16; i++) if (i != 8) begin
      b = 8'h01 << (i % 8);
      ea = (i < 8) ? 8'h34 : 8'h38;
      sa = (i < 8) ? 8'h24 : 8'h28;
      bus(1'b1, ea, b);
      pulse(i);
      tick(2);
      `CHK("wake on", 1'b0, wn)
      bus(1'b1, sa, 8'h00);
      rdx(sa, b);
      bus(1'b1, sa, b);
      tick(2);
      `CHK("wake off", 1'b1, wn)
      bus(1'b1, ea, 8'h00);
      pulse(i);
      tick(2);
      `CHK("wake masked", 1'b1, wn)
      rdx(sa, b);
      bus(1'b1, sa, b);
    end
    bus(1'b1, 8'h34, 8'h01);
    bus(1'b1, 8'h58, 8'h00);
    pulse(0);
    tick(2);
    `CHK("global off", 1'b1, wn)
    bus(1'b1, 8'h58, 8'h01);
    tick(2);
    `CHK("global on", 1'b0, wn)
    tick(1);
    `CHK("host count", 8'd16, wcnt)
    bus(1'b1, 8'h58, 8'h00);
    bus(1'b1, 8'h24, 8'hff);
    $display("test wake done");
    rdx(8'h80, 8'h07);
    bus(1'b1, 8'h88, 8'h07);
    pulse(3);
    tick(2);
    `CHK("irq masked", 1'b0, irq)
    rdx(8'h80, 8'h01);
    bus(1'b1, 8'h84, 8'h01);
    tick(2);
    `CHK("irq on", 1'b1, irq)
    bus(1'b1, 8'h88, 8'h01);
    tick(2);
    `CHK("irq cleared", 1'b0, irq)
    rdx(8'h80, 8'h00);
    $display("test interrupt done");
    bus(1'b1, 8'h40, 8'h03);
    tick(2);
    `CHK("lamps asleep", 2'b00, {gl, yl})
    slp <= 1'b1;
    for (i = 2; i < 4; i++) begin
      bus(1'b1, 8'h40, 8'(i));
      tick(2);
      `CHK("lamp steady", (i == 3) ? 2'b10 : 2'b01, {gl, yl})
    end
    bus(1'b1, 8'h40, 8'h00);
    tick(2);
    for (k = 0; yl !== 1'b0 && k < 40; k++) @(posedge clk);
    for (k = 0; yl !== 1'b1 && k < 40; k++) @(posedge clk);
    for (k = 0; yl === 1'b1 && k < 40; k++) @(posedge clk);
    `CHK("blink high", 5, k)
    for (k = 0; yl === 1'b0 && k < 40; k++) @(posedge clk);
    `CHK("blink low", 8, k)
    slp <= 1'b0;
    tick(2);
    `CHK("lamps off", 2'b00, {gl, yl})
    `CHK("queue empty", 0, exp_q.size())
    $display("test lamps done");
    stop_test();
  end
endmodule
`default_nettype wire
